//--- src/pwm_delay_psr_control_regs.sv
// Purpose: output delay and supply rejection control register group
// Assumes: modulator lines, master clock tick and measurement on i_core_clk
// Notes: power-down bit is held elsewhere and arrives as an input
`timescale 1ns/1ps
`include "supply_ctrl_regs.svh"
module pwm_delay_psr_control_regs
  import supply_ctrl_pkg::*;
#(
  parameter int CHANNELS = 3
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic i_powerdown_bit,
  input wire logic i_pwm_mclk_tick,
  input wire logic [CHANNELS-1:0] i_mod_a_pos,
  input wire logic [CHANNELS-1:0] i_mod_a_neg,
  input wire logic [CHANNELS-1:0] i_mod_b_pos,
  input wire logic [CHANNELS-1:0] i_mod_b_neg,
  output logic [CHANNELS-1:0] o_bridge_out_pos_a,
  output logic [CHANNELS-1:0] o_bridge_out_neg_a,
  output logic [CHANNELS-1:0] o_bridge_out_pos_b,
  output logic [CHANNELS-1:0] o_bridge_out_neg_b,
  input wire logic [23:0] i_supply_measure,
  output logic o_supply_reject_enable,
  output logic o_supply_reject_reset_n,
  output logic o_internal_reject_enable,
  output logic o_supply_sync_clock,
  output logic [23:0] o_supply_correction
);
  skew_reg_t skew_reg;
  supply_cfg_t cfg_reg;
  coef_t coef_reg;
  logic [23:0] meas_reg;
  logic [23:0] correction_next;
  logic [7:0] rdata_next;
  logic [CHANNELS-1:0] a_pos_dly;
  logic [CHANNELS-1:0] a_neg_dly;
  logic [CHANNELS-1:0] b_pos_dly;
  logic [CHANNELS-1:0] b_neg_dly;
  logic [CHANNELS-1:0] a_pos_out_reg;
  logic [CHANNELS-1:0] b_pos_out_reg;
  logic [2*CHANNELS-1:0] neg_dly;
  logic skew_wr;
  logic cfg_wr;
  logic coef_high_wr;
  logic coef_mid_wr;
  logic coef_low_wr;

  function automatic logic wr_hit(input logic en, wr, input logic [7:0] addr, target);
    wr_hit = en && wr && (addr == target);
  endfunction

  // Per-register write strobes
  always_comb begin
    skew_wr = wr_hit(i_clk_en, i_reg_wr, i_reg_addr, `ADDR_OUTPUT_SKEW);
    cfg_wr = wr_hit(i_clk_en, i_reg_wr, i_reg_addr, `ADDR_SUPPLY_CFG);
    coef_high_wr = wr_hit(i_clk_en, i_reg_wr, i_reg_addr, `ADDR_COEF_HIGH);
    coef_mid_wr = wr_hit(i_clk_en, i_reg_wr, i_reg_addr, `ADDR_COEF_MID);
    coef_low_wr = wr_hit(i_clk_en, i_reg_wr, i_reg_addr, `ADDR_COEF_LOW);
  end

  // Signed 2.22 times signed 1.18, shifted by exponent, back to 2.22
  function automatic logic [23:0] scale(input logic [23:0] meas, input coef_t c);
    logic signed [42:0] prod;
    logic signed [49:0] wide;
    prod = 43'($signed(meas) * $signed(c.mantissa));
    wide = 50'(prod) <<< c.exponent;
    scale = wide[`MANT_FRAC_BITS+23:`MANT_FRAC_BITS];
  endfunction

  // Delay register, writable only in power-down
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      skew_reg <= `SKEW_RESET;
    end else if (skew_wr && i_powerdown_bit) begin
      skew_reg <= i_reg_wdata;
    end
  end

  // Supply rejection configuration
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_reg <= `CFG_RESET;
    end else if (cfg_wr) begin
      cfg_reg <= {i_reg_wdata[7:5], 2'b00, i_reg_wdata[2:0]};
    end
  end

  // Calibration coefficient fields
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      coef_reg.exponent <= `EXP_RESET;
      coef_reg.mantissa <= `MANT_RESET;
    end else begin
      if (coef_high_wr) begin
        coef_reg.exponent <= i_reg_wdata[6:4];
        coef_reg.mantissa[18:16] <= i_reg_wdata[2:0];
      end
      if (coef_mid_wr) begin
        coef_reg.mantissa[15:8] <= i_reg_wdata;
      end
      if (coef_low_wr) begin
        coef_reg.mantissa[7:0] <= i_reg_wdata;
      end
    end
  end

  // Measurement tracks the feedback word, no write path
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meas_reg <= `MEAS_RESET;
    end else if (i_clk_en) begin
      meas_reg <= i_supply_measure;
    end
  end

  // Read mux, reserved bits zero
  always_comb begin
    rdata_next = 8'h00;
    case (i_reg_addr)
      `ADDR_OUTPUT_SKEW: rdata_next = skew_reg;
      `ADDR_SUPPLY_CFG: rdata_next = cfg_reg;
      `ADDR_COEF_HIGH: rdata_next = {1'b0, coef_reg.exponent, 1'b0, coef_reg.mantissa[18:16]};
      `ADDR_COEF_MID: rdata_next = coef_reg.mantissa[15:8];
      `ADDR_COEF_LOW: rdata_next = coef_reg.mantissa[7:0];
      `ADDR_MEAS_HIGH: rdata_next = meas_reg[23:16];
      `ADDR_MEAS_MID: rdata_next = meas_reg[15:8];
      `ADDR_MEAS_LOW: rdata_next = meas_reg[7:0];
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_clk_en && i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // Supply rejection control pins
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_supply_reject_enable <= 1'b0;
      o_internal_reject_enable <= 1'b0;
      o_supply_reject_reset_n <= 1'b0;
    end else if (i_clk_en) begin
      o_supply_reject_enable <= cfg_reg.supply_reject_enable;
      o_internal_reject_enable <= cfg_reg.supply_reject_enable;
      o_supply_reject_reset_n <= cfg_reg.supply_reject_reset_n;
    end
  end

  // Feedback correction, gated by feedback enable
  always_comb begin
    correction_next = cfg_reg.feedback_enable ? scale(meas_reg, coef_reg) : 24'h000000;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_supply_correction <= 24'h000000;
    end else if (i_clk_en) begin
      o_supply_correction <= correction_next;
    end
  end

  supply_sync_divider u_sync (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_code(cfg_reg.supply_sync_divider),
    .o_supply_sync_clock(o_supply_sync_clock)
  );

  // A pairs delayed against B pairs
  pwm_tap_delay #(.WIDTH(2*CHANNELS), .CODE_W(5), .MAX_DLY(31)) u_ab_delay (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_tick(i_pwm_mclk_tick),
    .i_code(skew_reg.ab_channel_delay),
    .i_din({i_mod_a_pos, i_mod_a_neg}),
    .o_dout({a_pos_dly, a_neg_dly})
  );

  // B pairs take the zero-code latency
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      b_pos_dly <= '0;
      b_neg_dly <= '0;
    end else if (i_clk_en) begin
      b_pos_dly <= i_mod_b_pos;
      b_neg_dly <= i_mod_b_neg;
    end
  end

  // Negative lines delayed against positive lines
  pwm_tap_delay #(.WIDTH(2*CHANNELS), .CODE_W(3), .MAX_DLY(7)) u_skew_delay (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_clk_en(i_clk_en),
    .i_tick(i_pwm_mclk_tick),
    .i_code(skew_reg.pair_skew_delay),
    .i_din({a_neg_dly, b_neg_dly}),
    .o_dout(neg_dly)
  );

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      a_pos_out_reg <= '0;
      b_pos_out_reg <= '0;
    end else if (i_clk_en) begin
      a_pos_out_reg <= a_pos_dly;
      b_pos_out_reg <= b_pos_dly;
    end
  end

  assign o_bridge_out_pos_a = a_pos_out_reg;
  assign o_bridge_out_pos_b = b_pos_out_reg;
  assign o_bridge_out_neg_a = neg_dly[2*CHANNELS-1:CHANNELS];
  assign o_bridge_out_neg_b = neg_dly[CHANNELS-1:0];

  property p_skew_locked;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (skew_wr && !i_powerdown_bit) |=> $stable(skew_reg);
  endproperty
  a_skew_locked: assert property (p_skew_locked) else $error("delay written outside power-down");

  property p_skew_write;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (skew_wr && i_powerdown_bit) |=> (skew_reg == $past(i_reg_wdata));
  endproperty
  a_skew_write: assert property (p_skew_write) else $error("delay write lost");

  property p_enable_pin;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (cfg_wr ##1 i_clk_en) |=>
        (o_supply_reject_enable == $past(i_reg_wdata[7], 2));
  endproperty
  a_enable_pin: assert property (p_enable_pin) else $error("enable pin mismatch");

  property p_reset_pin;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && !cfg_reg.supply_reject_reset_n) |=> !o_supply_reject_reset_n;
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin released early");

  property p_feedback_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && !cfg_reg.feedback_enable) |=> (o_supply_correction == 24'h000000);
  endproperty
  a_feedback_off: assert property (p_feedback_off) else $error("feedback active while off");

  property p_unity_coef;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && cfg_reg.feedback_enable && coef_reg == {3'h1, 19'h20000})
        |=> (o_supply_correction == $past(meas_reg));
  endproperty
  a_unity_coef: assert property (p_unity_coef) else $error("unity coefficient not unity");

  property p_meas_track;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clk_en |=> (meas_reg == $past(i_supply_measure));
  endproperty
  a_meas_track: assert property (p_meas_track) else $error("measurement stale");

  property p_meas_read;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && i_reg_rd && i_reg_addr == `ADDR_MEAS_HIGH) |=>
        (o_reg_rdata == $past(meas_reg[23:16]));
  endproperty
  a_meas_read: assert property (p_meas_read) else $error("measurement read wrong");

  property p_int_enable;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_clk_en |=> (o_internal_reject_enable == $past(cfg_reg.supply_reject_enable));
  endproperty
  a_int_enable: assert property (p_int_enable) else $error("internal enable wrong");

  property p_reset_release;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && cfg_reg.supply_reject_reset_n) |=> o_supply_reject_reset_n;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset pin held");

  property p_coef_write;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      coef_high_wr |=> (coef_reg.exponent == $past(i_reg_wdata[6:4]) &&
        coef_reg.mantissa[18:16] == $past(i_reg_wdata[2:0]));
  endproperty
  a_coef_write: assert property (p_coef_write) else $error("coefficient write lost");

  property p_b_latency;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en ##1 i_clk_en) |=>
        (o_bridge_out_pos_b == $past(i_mod_b_pos, 2));
  endproperty
  a_b_latency: assert property (p_b_latency) else $error("reference latency wrong");

  property p_neg_zero_skew;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en ##1 (i_clk_en && skew_reg.pair_skew_delay == 3'h0)) |=>
        (o_bridge_out_neg_b == $past(i_mod_b_neg, 2));
  endproperty
  a_neg_zero_skew: assert property (p_neg_zero_skew) else $error("zero skew not aligned");

  property p_a_zero_delay;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      ((i_clk_en && skew_reg.ab_channel_delay == 5'h00) ##1 i_clk_en) |=>
        (o_bridge_out_pos_a == $past(i_mod_a_pos, 2));
  endproperty
  a_a_zero_delay: assert property (p_a_zero_delay) else $error("zero channel delay wrong");

  c_skew_write: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    skew_wr && i_powerdown_bit);
  c_reject_on: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    o_supply_reject_enable && o_supply_reject_reset_n);
  c_sync_run: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    $rose(o_supply_sync_clock));
  c_feedback: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    cfg_reg.feedback_enable && o_supply_correction != 24'h000000);
  c_max_delay: cover property (@(posedge i_core_clk) disable iff (!i_rst_n)
    skew_reg == 8'hFF);
endmodule

//--- src/supply_ctrl_regs.svh
// Purpose: register offsets, field positions, reset values
// Assumes: 8-bit register port
// Notes: definitions only
`ifndef SUPPLY_CTRL_REGS_SVH
`define SUPPLY_CTRL_REGS_SVH
`define ADDR_OUTPUT_SKEW 8'h33
`define ADDR_SUPPLY_CFG 8'h34
`define ADDR_COEF_HIGH 8'h35
`define ADDR_COEF_MID 8'h36
`define ADDR_COEF_LOW 8'h37
`define ADDR_MEAS_HIGH 8'h3B
`define ADDR_MEAS_MID 8'h3C
`define ADDR_MEAS_LOW 8'h3D
`define SKEW_RESET 8'h00
`define CFG_RESET 8'h00
`define EXP_RESET 3'h2
`define MANT_RESET 19'h25868
`define MEAS_RESET 24'h000000
`define SYNC_OFF 3'h0
`define SYNC_UNDEF 3'h7
`define SYNC_BIT_BASE 4'h3
`define MANT_FRAC_BITS 18
`endif

//--- src/supply_ctrl_pkg.sv
// Purpose: shared types of the delay and supply control block
// Assumes: nothing
// Notes: field order follows the register bit order
package supply_ctrl_pkg;
  typedef struct packed {
    logic [2:0] pair_skew_delay;
    logic [4:0] ab_channel_delay;
  } skew_reg_t;
  typedef struct packed {
    logic supply_reject_enable;
    logic supply_reject_reset_n;
    logic feedback_enable;
    logic [1:0] reserved;
    logic [2:0] supply_sync_divider;
  } supply_cfg_t;
  typedef struct packed {
    logic [2:0] exponent;
    logic [18:0] mantissa;
  } coef_t;
endpackage

//--- src/pwm_tap_delay.sv
// Purpose: delays a group of PWM lines by a code of master clock periods
// Assumes: i_tick marks one PWM master clock period
// Notes: code zero gives the one-cycle register latency only
`timescale 1ns/1ps
module pwm_tap_delay #(
  parameter int WIDTH = 6,
  parameter int CODE_W = 5,
  parameter int MAX_DLY = 31
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_tick,
  input wire logic [CODE_W-1:0] i_code,
  input wire logic [WIDTH-1:0] i_din,
  output logic [WIDTH-1:0] o_dout
);
  logic [MAX_DLY-1:0][WIDTH-1:0] tap_reg;

  // Shift one stage per master clock period
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tap_reg <= '0;
    end else if (i_clk_en && i_tick) begin
      tap_reg <= {tap_reg[MAX_DLY-2:0], i_din};
    end
  end

  // Select tap by code
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dout <= '0;
    end else if (i_clk_en) begin
      if (i_code == '0) begin
        o_dout <= i_din;
      end else begin
        o_dout <= tap_reg[i_code - 1'b1];
      end
    end
  end

  property p_zero_delay;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && i_code == '0) |=> (o_dout == $past(i_din));
  endproperty
  a_zero_delay: assert property (p_zero_delay) else $error("zero code not pass-through");

  property p_tap_select;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && i_code != '0) |=> (o_dout == $past(tap_reg[i_code - 1'b1]));
  endproperty
  a_tap_select: assert property (p_tap_select) else $error("wrong delay tap");
endmodule

//--- src/supply_sync_divider.sv
// Purpose: makes the supply sync clock from the crystal clock
// Assumes: core clock is the crystal clock
// Notes: disabled codes hold the output low and clear the counter
`timescale 1ns/1ps
`include "supply_ctrl_regs.svh"
module supply_sync_divider (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic [2:0] i_code,
  output logic o_supply_sync_clock
);
  logic [9:0] count_reg;
  logic off;

  function automatic logic [3:0] div_bit(input logic [2:0] code);
    div_bit = 4'(code) + `SYNC_BIT_BASE;
  endfunction

  assign off = (i_code == `SYNC_OFF) || (i_code == `SYNC_UNDEF);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= '0;
    end else if (i_clk_en) begin
      count_reg <= off ? '0 : count_reg + 1'b1;
    end
  end

  // Divide by two to the power code plus four
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_supply_sync_clock <= 1'b0;
    end else if (i_clk_en) begin
      o_supply_sync_clock <= off ? 1'b0 : count_reg[div_bit(i_code)];
    end
  end

  property p_sync_off;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && off) |=> !o_supply_sync_clock;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync clock runs while off");

  property p_sync_div32;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_clk_en && i_code == 3'h1) |=> (o_supply_sync_clock == $past(count_reg[4]));
  endproperty
  a_sync_div32: assert property (p_sync_div32) else $error("divide by 32 wrong");
endmodule

//--- test/supply_feedback_model.sv
// Purpose: behavioural model of the external supply rejection feedback circuit
// Assumes: measurement leaves on the core clock, no synchroniser needed
// Notes: clean supply reads 1.0, ripple is added by the bench
`timescale 1ns/1ps
module supply_feedback_model (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_supply_reject_enable,
  input wire logic i_supply_reject_reset_n,
  input wire logic [23:0] i_ripple,
  output logic [23:0] o_supply_measure
);
  // Held in reset or disabled gives a zero reading
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_supply_measure <= 24'h000000;
    end else if (!i_supply_reject_reset_n || !i_supply_reject_enable) begin
      o_supply_measure <= 24'h000000;
    end else begin
      o_supply_measure <= 24'h400000 + i_ripple;
    end
  end
endmodule

//--- test/pwm_delay_psr_control_regs_tb.sv
// Purpose: self-checking bench of the delay and supply control registers
// Assumes: one register access at a time, read data one cycle after the read edge
// Notes: delays checked relative to the B positive line
`timescale 1ns/1ps
module pwm_delay_psr_control_regs_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clk_en = 1'b1;
  logic tick = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic powerdown_bit = 1'b0;
  logic [2:0] a_pos = 3'h0, a_neg = 3'h0, b_pos = 3'h0, b_neg = 3'h0;
  logic [23:0] ripple = 24'h000000;
  logic [7:0] rdata;
  logic [2:0] oa_pos, oa_neg, ob_pos, ob_neg;
  logic [23:0] meas, corr;
  logic rej_en, rej_rst_n, int_en, sync;
  int err_count = 0;
  int n_compared = 0;
  int n;
  logic [7:0] ra [8] = '{8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3B, 8'h3C, 8'h3D};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h22, 8'h58, 8'h68, 8'h00, 8'h00, 8'h00};

  pwm_delay_psr_control_regs #(.CHANNELS(3)) u_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_powerdown_bit(powerdown_bit), .i_pwm_mclk_tick(tick),
    .i_mod_a_pos(a_pos), .i_mod_a_neg(a_neg), .i_mod_b_pos(b_pos), .i_mod_b_neg(b_neg),
    .o_bridge_out_pos_a(oa_pos), .o_bridge_out_neg_a(oa_neg),
    .o_bridge_out_pos_b(ob_pos), .o_bridge_out_neg_b(ob_neg),
    .i_supply_measure(meas), .o_supply_reject_enable(rej_en),
    .o_supply_reject_reset_n(rej_rst_n), .o_internal_reject_enable(int_en),
    .o_supply_sync_clock(sync), .o_supply_correction(corr)
  );

  supply_feedback_model u_psr (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_supply_reject_enable(rej_en),
    .i_supply_reject_reset_n(rej_rst_n), .i_ripple(ripple), .o_supply_measure(meas)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {16'h0, exp}, {16'h0, rdata});
  endtask

  // Cycles to the next rising edge of the sync clock, 2100 when none
  task rise(output int cnt);
    logic p;
    cnt = 0;
    p = sync;
    while (cnt < 2100) begin
      @(posedge clk);
      #1;
      cnt++;
      if (sync === 1'b1 && p === 1'b0) begin
        return;
      end
      p = sync;
    end
  endtask

  // Step all modulator lines and time each output against B positive
  task dly(input logic [7:0] code);
    int tp, ta, tn, tan, k;
    wr_reg(8'h33, code);
    a_pos <= 3'h0;
    a_neg <= 3'h0;
    b_pos <= 3'h0;
    b_neg <= 3'h0;
    repeat (45) @(posedge clk);
    a_pos <= 3'h7;
    a_neg <= 3'h7;
    b_pos <= 3'h7;
    b_neg <= 3'h7;
    tp = -1;
    ta = -1;
    tn = -1;
    tan = -1;
    for (k = 0; k < 80; k++) begin
      @(posedge clk);
      #1;
      if (tp < 0 && ob_pos[0] === 1'b1) tp = k;
      if (ta < 0 && oa_pos[0] === 1'b1) ta = k;
      if (tn < 0 && ob_neg[0] === 1'b1) tn = k;
      if (tan < 0 && oa_neg[0] === 1'b1) tan = k;
    end
    chk("ab delay", {19'h0, code[4:0]}, 24'(ta - tp));
    chk("skew delay", {21'h0, code[7:5]}, 24'(tn - tp));
    chk("ab plus skew", 24'(code[4:0] + code[7:5]), 24'(tan - tp));
  endtask

  initial begin
    #400000;
    err_count++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset_n out", 24'h0, {23'h0, rej_rst_n});
    chk("internal en", 24'h0, {23'h0, int_en});
    chk("correction", 24'h0, corr);
    for (int i = 0; i < 8; i++) begin
      rd_reg(ra[i], rv[i]);
    end
    rd_reg(8'h40, 8'h00);
    // Delay writes refused outside power-down
    wr_reg(8'h33, 8'hFF);
    rd_reg(8'h33, 8'h00);
    @(posedge clk);
    powerdown_bit <= 1'b1;
    dly(8'hFF);
    dly(8'h26);
    dly(8'h00);
    @(posedge clk);
    powerdown_bit <= 1'b0;
    wr_reg(8'h33, 8'h5A);
    rd_reg(8'h33, 8'h00);
    // Enable and reset outputs, code seven keeps sync off
    wr_reg(8'h34, 8'hFF);
    rd_reg(8'h34, 8'hE7);
    chk("enable out", 24'h1, {23'h0, rej_en});
    chk("internal en", 24'h1, {23'h0, int_en});
    chk("reset_n out", 24'h1, {23'h0, rej_rst_n});
    rise(n);
    chk("sync code 7", 24'd2100, 24'(n));
    wr_reg(8'h34, 8'h80);
    rd_reg(8'h34, 8'h80);
    chk("reset_n held", 24'h0, {23'h0, rej_rst_n});
    for (int c = 0; c < 7; c++) begin
      wr_reg(8'h34, 8'hC0 | 8'(c));
      rise(n);
      if (c != 0) begin
        rise(n);
      end
      chk($sformatf("sync code %0d", c), (c == 0) ? 24'd2100 : 24'(32 << (c - 1)), 24'(n));
    end
    wr_reg(8'h34, 8'h00);
    rd_reg(8'h34, 8'h00);
    chk("enable off", 24'h0, {23'h0, rej_en});
    // Measurement and coefficient path
    wr_reg(8'h34, 8'hE0);
    wr_reg(8'h35, 8'h12);
    wr_reg(8'h36, 8'h00);
    wr_reg(8'h37, 8'h00);
    repeat (4) @(posedge clk);
    rd_reg(8'h3B, 8'h40);
    rd_reg(8'h3C, 8'h00);
    chk("unity coef", 24'h400000, corr);
    wr_reg(8'h35, 8'h16);
    repeat (4) @(posedge clk);
    #1;
    chk("negative coef", 24'hC00000, corr);
    rd_reg(8'h35, 8'h16);
    @(posedge clk);
    ripple <= 24'h013345;
    wr_reg(8'h3B, 8'h00);
    repeat (3) @(posedge clk);
    rd_reg(8'h3B, 8'h41);
    rd_reg(8'h3C, 8'h33);
    rd_reg(8'h3D, 8'h45);
    wr_reg(8'h34, 8'hC0);
    repeat (4) @(posedge clk);
    #1;
    chk("feedback off", 24'h0, corr);
    test_done();
  end
endmodule
